// ==== hdl/tapid_pkg.sv ====
// package: constants and types for the test access port identification block
// What this block does
// - one standard scan port with boundary scan
// - four-bit instruction, thirty-two-bit data shift
// - chip port reached through scan port
// - test reset low keeps link-domain logic in reset
// - identity instruction shifts out identification word
// - user-code instruction shifts out user-code word
// - user tag from security bits 22 to 31
// - unprogrammed fuses give all-zero user tag
// - tag field is fuse-loaded extension bits
package tapid_pkg;
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int BSR_W = 8;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_USERCODE = 4'h3;
  localparam logic [3:0] IR_CHIPTAP = 4'h4;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_RESET = IR_IDCODE;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam int SEC_TAG_LSB = 22;
  localparam int SEC_TAG_W = 10;
  localparam int UC_TAG_LSB = 22;
  localparam int UC_UNUSED_LSB = 18;
  localparam int UC_REV_W = 18;
  localparam int TRST_MIN_NS = 100;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  localparam logic [31:0] DR_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    TST_RESET = 4'h0, TST_IDLE = 4'h1, TST_SEL_DR = 4'h3,
    TST_CAP_DR = 4'h2, TST_SH_DR = 4'h6, TST_EX1_DR = 4'h7,
    TST_PA_DR = 4'h5, TST_EX2_DR = 4'h4, TST_UP_DR = 4'hC,
    TST_SEL_IR = 4'hD, TST_CAP_IR = 4'hF, TST_SH_IR = 4'hE,
    TST_EX1_IR = 4'hA, TST_PA_IR = 4'hB, TST_EX2_IR = 4'h9,
    TST_UP_IR = 4'h8
  } tapid_state_t;

  typedef struct packed {
    logic tms;
    logic tdi;
  } tapid_link_t;
endpackage : tapid_pkg

// ==== hdl/tapid_sync.sv ====
// two-flop level synchroniser
`timescale 1ns/1ps
module tapid_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta <= '0;
      o_q <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule : tapid_sync

// ==== hdl/tapid_top.sv ====
// scan port controller with identification and user-code words
`timescale 1ns/1ps
module tapid_top #(
  parameter logic [3:0] ID_VERSION = 4'h1,
  parameter logic [15:0] ID_PART = 16'h1234,
  parameter logic [10:0] ID_MFR = 11'h155,
  parameter logic [17:0] SI_REV = 18'h00001,
  parameter int BSR_LEN = tapid_pkg::BSR_W
) (
  // system clock domain
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [31:0] i_sec_reg,
  output logic [9:0] o_fuse_user_tag,
  output logic o_chip_sel,
  // link domain
  input wire logic i_tck,
  input wire logic i_trst_n,
  input wire tapid_pkg::tapid_link_t i_link,
  output logic o_tdo,
  output logic o_tdo_oe_n,
  // chip-level port
  input wire logic i_chip_tdo,
  output logic o_chip_tdi,
  // boundary scan cells
  input wire logic [BSR_LEN-1:0] i_pins,
  output logic [BSR_LEN-1:0] o_pins,
  output logic o_pins_drive
);
  // security register is captured after reset release, not at reset
  logic [31:0] sec;
  logic rst_seen;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sec <= tapid_pkg::SEC_RESET;
      rst_seen <= 1'b0;
    end
    else if (!rst_seen)
    begin
      sec <= i_sec_reg;
      rst_seen <= 1'b1;
    end
  end

  // unprogrammed fuses read zero, so the tag is zero too
  logic [9:0] fuse_user_tag;
  assign fuse_user_tag = sec[tapid_pkg::SEC_TAG_LSB +: 10];
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_fuse_user_tag <= '0;
    else
      o_fuse_user_tag <= fuse_user_tag;
  end

  // tag word crosses to link domain; it is static after capture
  logic [9:0] tag_tck;
  tapid_sync #(.W(10)) u_tag_sync (
    .i_clk(i_tck),
    .i_arst_n(i_trst_n),
    .i_d(o_fuse_user_tag),
    .o_q(tag_tck)
  );

  logic [31:0] id_word;
  logic [31:0] uc_word;
  assign id_word = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
  assign uc_word = {tag_tck, 4'h0, SI_REV};

  // tap state machine, held in reset while test reset is low
  tapid_pkg::tapid_state_t st;
  tapid_pkg::tapid_state_t next_st;
  always_comb
  begin
    next_st = st;
    case (st)
      tapid_pkg::TST_RESET:
        next_st = i_link.tms ? tapid_pkg::TST_RESET : tapid_pkg::TST_IDLE;
      tapid_pkg::TST_IDLE:
        next_st = i_link.tms ? tapid_pkg::TST_SEL_DR : tapid_pkg::TST_IDLE;
      tapid_pkg::TST_SEL_DR:
        next_st = i_link.tms ? tapid_pkg::TST_SEL_IR : tapid_pkg::TST_CAP_DR;
      tapid_pkg::TST_CAP_DR:
        next_st = i_link.tms ? tapid_pkg::TST_EX1_DR : tapid_pkg::TST_SH_DR;
      tapid_pkg::TST_SH_DR:
        next_st = i_link.tms ? tapid_pkg::TST_EX1_DR : tapid_pkg::TST_SH_DR;
      tapid_pkg::TST_EX1_DR:
        next_st = i_link.tms ? tapid_pkg::TST_UP_DR : tapid_pkg::TST_PA_DR;
      tapid_pkg::TST_PA_DR:
        next_st = i_link.tms ? tapid_pkg::TST_EX2_DR : tapid_pkg::TST_PA_DR;
      tapid_pkg::TST_EX2_DR:
        next_st = i_link.tms ? tapid_pkg::TST_UP_DR : tapid_pkg::TST_SH_DR;
      tapid_pkg::TST_UP_DR:
        next_st = i_link.tms ? tapid_pkg::TST_SEL_DR : tapid_pkg::TST_IDLE;
      tapid_pkg::TST_SEL_IR:
        next_st = i_link.tms ? tapid_pkg::TST_RESET : tapid_pkg::TST_CAP_IR;
      tapid_pkg::TST_CAP_IR:
        next_st = i_link.tms ? tapid_pkg::TST_EX1_IR : tapid_pkg::TST_SH_IR;
      tapid_pkg::TST_SH_IR:
        next_st = i_link.tms ? tapid_pkg::TST_EX1_IR : tapid_pkg::TST_SH_IR;
      tapid_pkg::TST_EX1_IR:
        next_st = i_link.tms ? tapid_pkg::TST_UP_IR : tapid_pkg::TST_PA_IR;
      tapid_pkg::TST_PA_IR:
        next_st = i_link.tms ? tapid_pkg::TST_EX2_IR : tapid_pkg::TST_PA_IR;
      tapid_pkg::TST_EX2_IR:
        next_st = i_link.tms ? tapid_pkg::TST_UP_IR : tapid_pkg::TST_SH_IR;
      tapid_pkg::TST_UP_IR:
        next_st = i_link.tms ? tapid_pkg::TST_SEL_DR : tapid_pkg::TST_IDLE;
      default:
        next_st = tapid_pkg::TST_RESET;
    endcase
  end

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
      st <= tapid_pkg::TST_RESET;
    else
      st <= next_st;
  end

  // instruction shift and hold registers
  logic [3:0] ir_sh;
  logic [3:0] ir;
  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
      ir_sh <= '0;
    else if (st == tapid_pkg::TST_CAP_IR)
      ir_sh <= {2'h0, tapid_pkg::IR_CAPTURE};
    else if (st == tapid_pkg::TST_SH_IR)
      ir_sh <= {i_link.tdi, ir_sh[3:1]};
  end

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
      ir <= tapid_pkg::IR_RESET;
    else if (st == tapid_pkg::TST_RESET)
      ir <= tapid_pkg::IR_RESET;
    else if (st == tapid_pkg::TST_UP_IR)
      ir <= ir_sh;
  end

  // data shift register: 32 bits; bypass uses bit 0 only
  logic [31:0] dr;
  logic [BSR_LEN-1:0] bsr;
  logic bsr_sel;
  logic chip_sel;
  assign bsr_sel = (ir == tapid_pkg::IR_EXTEST) ||
                   (ir == tapid_pkg::IR_SAMPLE);
  assign chip_sel = (ir == tapid_pkg::IR_CHIPTAP);

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
      dr <= tapid_pkg::DR_RESET;
    else if (st == tapid_pkg::TST_CAP_DR)
    begin
      case (ir)
        tapid_pkg::IR_IDCODE: dr <= id_word;
        tapid_pkg::IR_USERCODE: dr <= uc_word;
        default: dr <= '0;
      endcase
    end
    else if (st == tapid_pkg::TST_SH_DR)
    begin
      if (ir == tapid_pkg::IR_IDCODE || ir == tapid_pkg::IR_USERCODE)
        dr <= {i_link.tdi, dr[31:1]};
      else
        dr <= {31'h0, i_link.tdi};
    end
  end

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
      bsr <= '0;
    else if (bsr_sel && st == tapid_pkg::TST_CAP_DR)
      bsr <= i_pins;
    else if (bsr_sel && st == tapid_pkg::TST_SH_DR)
      bsr <= {i_link.tdi, bsr[BSR_LEN-1:1]};
  end

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      o_pins <= '0;
      o_pins_drive <= 1'b0;
    end
    else
    begin
      if (bsr_sel && st == tapid_pkg::TST_UP_DR)
        o_pins <= bsr;
      o_pins_drive <= (ir == tapid_pkg::IR_EXTEST);
    end
  end

  // chip-level port rides the same data path; its own tms comes from
  // the chip tap side, only data is forwarded here
  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
      o_chip_tdi <= 1'b0;
    else
      o_chip_tdi <= chip_sel && (st == tapid_pkg::TST_SH_DR) && i_link.tdi;
  end

  // tdo changes on falling tck, per usual scan timing
  logic tdo_bit;
  always_comb
  begin
    tdo_bit = dr[0];
    if (st == tapid_pkg::TST_SH_IR)
      tdo_bit = ir_sh[0];
    else if (bsr_sel)
      tdo_bit = bsr[0];
    else if (chip_sel)
      tdo_bit = i_chip_tdo;
  end

  always_ff @(negedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      o_tdo <= 1'b0;
      o_tdo_oe_n <= 1'b1;
    end
    else
    begin
      o_tdo <= tdo_bit;
      o_tdo_oe_n <= !(st == tapid_pkg::TST_SH_IR ||
                      st == tapid_pkg::TST_SH_DR);
    end
  end

  // loaded with ir so it settles while the link clock stands still
  logic chip_sel_q;
  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
      chip_sel_q <= 1'b0;
    else if (st == tapid_pkg::TST_RESET)
      chip_sel_q <= 1'b0;
    else if (st == tapid_pkg::TST_UP_IR)
      chip_sel_q <= (ir_sh == tapid_pkg::IR_CHIPTAP);
  end
  tapid_sync #(.W(1)) u_sel_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(chip_sel_q),
    .o_q(o_chip_sel)
  );

  a_reset_holds: assert property (@(posedge i_tck)
    !i_trst_n |-> st == tapid_pkg::TST_RESET)
    else $error("tap left reset while test reset low");

  sequence s_cap_id;
    st == tapid_pkg::TST_CAP_DR && ir == tapid_pkg::IR_IDCODE;
  endsequence
  a_id_capture: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    s_cap_id |=> dr == id_word)
    else $error("identification word not captured");

  a_id_bit0: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    s_cap_id ##1 st == tapid_pkg::TST_SH_DR |-> tdo_bit == 1'b1)
    else $error("identification bit zero not one");

  sequence s_cap_uc;
    st == tapid_pkg::TST_CAP_DR && ir == tapid_pkg::IR_USERCODE;
  endsequence
  a_uc_capture: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    s_cap_uc |=> dr == uc_word)
    else $error("user-code word not captured");

  a_uc_unused: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    s_cap_uc |=> dr[21:18] == 4'h0)
    else $error("unused field not zero");

  a_tag_source: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $past(rst_seen) |-> o_fuse_user_tag == sec[31:22])
    else $error("user tag not from security bits");

  a_ir_shift: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    st == tapid_pkg::TST_SH_IR && next_st == tapid_pkg::TST_SH_IR
    |=> ir_sh[3] == $past(i_link.tdi))
    else $error("instruction shift wrong");

  a_ir_update: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    st == tapid_pkg::TST_UP_IR |=> ir == $past(ir_sh))
    else $error("instruction not updated");

  a_tms_reset: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    i_link.tms [*5] |=> st == tapid_pkg::TST_RESET)
    else $error("five tms highs did not reset");
endmodule : tapid_top

// ==== sim/tapid_host.sv ====
// jtag host model that frames scans on a gated link clock
`timescale 1ns/1ps
module tapid_host (
  // link outputs
  output logic o_tck,
  output logic o_trst_n,
  output tapid_pkg::tapid_link_t o_link,
  // link input and scan result
  input wire logic i_tdo,
  output logic o_done,
  output logic [31:0] o_word
);
  initial
  begin
    o_tck = 1'b0;
    o_trst_n = 1'b0;
    o_link = '0;
    o_done = 1'b0;
    o_word = '0;
  end

  // the clock stands still between frames, as a real probe leaves it
  task automatic step(input logic m, input logic d, output logic q);
    o_link.tms = m;
    o_link.tdi = d;
    #40 o_tck = 1'b1;
    q = i_tdo;
    #40 o_tck = 1'b0;
  endtask : step

  // n clock pulses while reset is held show the port ignores them
  task automatic hold_reset(input int n);
    logic q;
    o_trst_n = 1'b0;
    #(2 * tapid_pkg::TRST_MIN_NS);
    repeat (n) step(1'b0, 1'b0, q);
    #10 o_trst_n = 1'b1;
  endtask : hold_reset

  // idle pulses first give the tag synchroniser its edges
  task automatic scan(input logic ir, input logic [31:0] din, input int n);
    logic q;
    logic [31:0] got;
    got = '0;
    repeat (3) step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      got[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    o_word = got;
    o_done = 1'b1;
    #1 o_done = 1'b0;
  endtask : scan
endmodule : tapid_host

// ==== sim/test_access_port_identification_bench.sv ====
// self-checking bench for the scan port identification block
`timescale 1ns/1ps
module test_access_port_identification_bench;
  localparam logic [3:0] VER = 4'h1;
  localparam logic [15:0] PART = 16'h0A5C; // arbitrary value
  localparam logic [10:0] MFR = 11'h2B3; // arbitrary value
  localparam logic [17:0] REV = 18'h00003;
  localparam logic [31:0] ID_WORD = {VER, PART, MFR, 1'b1};
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b1;
  logic [31:0] sec = '0;
  logic chip_tdo = 1'b0;
  logic [7:0] pins = '0;
  logic [7:0] pins_out;
  logic [9:0] tag;
  logic chip_sel, chip_tdi, tdo, tdo_oe_n, pins_drive, tck, trst_n, done;
  logic [31:0] word;
  logic [31:0] rng = 32'h1C8EC195;
  tapid_pkg::tapid_link_t link;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int total_checks = 0;
  int tdi_ones = 0;

  // forwarded data bits seen on the chip-level port
  always @(negedge tck)
    if (chip_tdi === 1'b1)
      tdi_ones++;

  always #12.5 i_clk = ~i_clk;

  tapid_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR), .SI_REV(REV),
    .BSR_LEN(8)) u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sec_reg(sec),
    .o_fuse_user_tag(tag), .o_chip_sel(chip_sel), .i_tck(tck),
    .i_trst_n(trst_n), .i_link(link), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
    .i_chip_tdo(chip_tdo), .o_chip_tdi(chip_tdi), .i_pins(pins),
    .o_pins(pins_out), .o_pins_drive(pins_drive));

  // a released tdo floats high through the board pull-up
  tapid_host u_host (.o_tck(tck), .o_trst_n(trst_n), .o_link(link),
    .i_tdo(tdo_oe_n ? 1'b1 : tdo), .o_done(done), .o_word(word));

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  always @(posedge done)
    if (exp_q.size() == 0)
      check(32'h0, 32'h1);
    else
      check(word, exp_q.pop_front());

  task automatic expect_scan(input logic ir, input logic [31:0] din,
    input int n, input logic [31:0] exp);
    exp_q.push_back(exp);
    u_host.scan(ir, din, n);
  endtask : expect_scan

  task automatic sys_reset(input logic [31:0] v);
    @(posedge i_clk);
    #2 i_arst_n = 1'b0;
    sec = v;
    repeat (2) @(posedge i_clk);
    #2 i_arst_n = 1'b1;
    repeat (4) @(posedge i_clk);
  endtask : sys_reset

  task automatic wait_sel(input logic v);
    int k;
    k = 0;
    while (chip_sel !== v && k < 20)
    begin
      @(posedge i_clk);
      k++;
    end
    check(chip_sel, v);
  endtask : wait_sel

  initial
  begin
    #200000;
    miscompares++;
    $display("[ERR] %0t run timed out", $time);
    complete_run();
  end

  initial
  begin
    logic [31:0] v;
    logic q;
    int ones;
    #1 i_arst_n = 1'b0;
    repeat (2) @(posedge i_clk);
    #2 i_arst_n = 1'b1;
    u_host.hold_reset(0);
    expect_scan(0, rnd(), 32, ID_WORD);
    for (int t = 0; t < 2; t++)
    begin
      v = t ? rnd() : 32'h0;
      sys_reset(v);
      check(tag, v[31:22]);
      expect_scan(1, tapid_pkg::IR_USERCODE, 4, 32'h1);
      expect_scan(0, rnd(), 32, {v[31:22], 4'h0, REV});
    end
    $display("test usercode done");
    for (int b = 0; b < 2; b++)
    begin
      v = rnd();
      expect_scan(1, b ? 4'h9 : tapid_pkg::IR_BYPASS, 4, 32'h1);
      expect_scan(0, v, 32, {v[30:0], 1'b0});
    end
    $display("test bypass done");
    expect_scan(1, tapid_pkg::IR_CHIPTAP, 4, 32'h1);
    wait_sel(1'b1);
    ones = 0;
    for (int b = 0; b < 2; b++)
    begin
      @(posedge i_clk);
      #2 chip_tdo = b[0];
      v = rnd();
      ones += $countones(v);
      expect_scan(0, v, 32, {32{b[0]}});
    end
    check(tdi_ones, ones);
    $display("test chip port done");
    v = rnd();
    @(posedge i_clk);
    #2 pins = v[7:0];
    expect_scan(1, tapid_pkg::IR_SAMPLE, 4, 32'h1);
    wait_sel(1'b0);
    expect_scan(0, rnd(), 8, {24'h0, v[7:0]});
    expect_scan(1, tapid_pkg::IR_EXTEST, 4, 32'h1);
    v = rnd();
    expect_scan(0, v, 8, {24'h0, pins});
    check(pins_out, v[7:0]);
    check(pins_drive, 1'b1);
    $display("test boundary scan done");
    expect_scan(1, tapid_pkg::IR_USERCODE, 4, 32'h1);
    u_host.hold_reset(3);
    check(tdo_oe_n, 1'b1);
    expect_scan(0, rnd(), 32, ID_WORD);
    expect_scan(1, tapid_pkg::IR_USERCODE, 4, 32'h1);
    repeat (5) u_host.step(1'b1, 1'b0, q);
    expect_scan(0, rnd(), 32, ID_WORD);
    $display("test mid-run reset done");
    if (exp_q.size() != 0)
      check(32'h0, 32'h1);
    complete_run();
  end
endmodule : test_access_port_identification_bench
